// ### rtl/ccc_top.sv
// clock output channel config: register port, clock input sampling, channel and aux drivers
// assumes VCO divider, cleanup loop and sync inputs are slow against the 250 MHz clock
//
// Function
// RULE1: the channel divider divides its input by the 10-bit value plus one, 0 passes, 1023 gives 1024.
// RULE2: the divide value takes bits 7:0 from one register and bits 9:8 from bits 1:0 of the next.
// RULE3: a 6-bit phase field sets the divider start phase taken when a sync is asserted; the code loads it on the first cycle after sync is released.
// RULE4: each phase count delays the divider by half an input period, 63 giving 31.5 periods.
// RULE5: mode 0110 drives both pins as CMOS with the true divider phase.
// RULE6: mode 0111 drives the positive pin true and the negative pin complement.
// RULE7: mode 1000 drives only the positive pin true and 1001 only the negative pin true.
// RULE8: mode 1011 drives both pins with the complement of the divider output.
// RULE9: mode 1100 drives the positive pin complement and the negative pin true.
// RULE10: mode 1101 drives the positive pin complement and floats the negative pin.
// RULE11: mode 1110 floats the positive pin and drives the negative pin complement.
// RULE12: three select bits pick the first or second VCO divider for channels 6, 5 and 4.
// RULE13: the aux output strength bit gives weak drive when set and strong when clear.
// RULE14: the aux divider code is one-hot, zero divides by 1, bits 0 to 3 give 2, 4, 8, 16, default 2.
// RULE15: software writes only the five permitted aux divider codes.
// RULE16: any other aux divider code behaves as divide by 1.
`timescale 1ns/100ps

module ccc_top
  import ccc_pkg::*;
#(
  // which of channels 4, 5, 6 this divider serves
  parameter int CHAN_IDX = 4,
  parameter int DIV_W = 10,
  parameter int PHASE_W = 6
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [`CCC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`CCC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`CCC_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic first_vco_divider_i,
  input wire logic second_vco_divider_i,
  input wire logic input_cleanup_loop_i,
  input wire logic sync_i,
  output logic chan_pos_o,
  output logic chan_pos_oe_o,
  output logic chan_neg_o,
  output logic chan_neg_oe_o,
  output logic cleanup_loop_aux_output_o,
  output logic cleanup_loop_aux_weak_o,
  output logic [2:0] channel_source_select_o
);

  localparam int N_PIN = 4;
  localparam int PIN_M1 = 0;
  localparam int PIN_M2 = 1;
  localparam int PIN_CL = 2;
  localparam int PIN_SYNC = 3;
  localparam int SEL_BIT = CHAN_IDX - 4;

  // register file
  logic [3:0] drv_mode_ff;
  logic [7:0] div_low_ff;
  logic [1:0] div_high_ff;
  logic [5:0] phase_ff;
  logic [2:0] src_sel_ff;
  logic aux_weak_ff;
  logic [3:0] aux_div_ff;
  logic [`CCC_DATA_W-1:0] rdata_ff;
  logic rvalid_ff;

  wire logic hit_mode = (reg_addr_i == `CCC_OFS_DRIVER_MODE);
  wire logic hit_div_low = (reg_addr_i == `CCC_OFS_CHAN_DIV_LOW);
  wire logic hit_phase = (reg_addr_i == `CCC_OFS_CHAN_PHASE_DIV_HIGH);
  wire logic hit_aux = (reg_addr_i == `CCC_OFS_AUX_OUT_CTRL);

  wire logic wr_mode = reg_wr_i && hit_mode;
  wire logic wr_div_low = reg_wr_i && hit_div_low;
  wire logic wr_phase = reg_wr_i && hit_phase;
  wire logic wr_aux = reg_wr_i && hit_aux;

  // bits outside the implemented fields read back as zero
  wire logic [7:0] rd_mode = {4'h0, drv_mode_ff};
  wire logic [7:0] rd_phase = {phase_ff, div_high_ff};
  wire logic [7:0] rd_aux = {src_sel_ff, aux_weak_ff, aux_div_ff};
  wire logic [7:0] nxt_rdata = hit_mode ? rd_mode :
                               hit_div_low ? div_low_ff :
                               hit_phase ? rd_phase :
                               hit_aux ? rd_aux : 8'h00;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drv_mode_ff <= `CCC_RST_DRIVER_MODE;
      div_low_ff <= `CCC_RST_DIV_LOW;
    end else if (ce_i) begin
      if (wr_mode) begin
        drv_mode_ff <= reg_wdata_i[`CCC_DRV_MODE_MSB:`CCC_DRV_MODE_LSB];
      end
      if (wr_div_low) begin
        div_low_ff <= reg_wdata_i; // RULE2
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_high_ff <= `CCC_RST_DIV_HIGH;
      phase_ff <= `CCC_RST_PHASE;
    end else if (ce_i && wr_phase) begin
      div_high_ff <= reg_wdata_i[`CCC_DIV_HIGH_MSB:`CCC_DIV_HIGH_LSB]; // RULE2
      phase_ff <= reg_wdata_i[`CCC_PHASE_MSB:`CCC_PHASE_LSB]; // RULE3
    end
  end

  // no check on the aux divider code; illegal codes fall back in the divider
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_sel_ff <= `CCC_RST_SRC_SEL;
      aux_weak_ff <= `CCC_RST_AUX_STRENGTH;
      aux_div_ff <= `CCC_RST_AUX_DIV; // RULE14
    end else if (ce_i && wr_aux) begin
      src_sel_ff <= reg_wdata_i[`CCC_SRC_SEL_MSB:`CCC_SRC_SEL_LSB]; // RULE12
      aux_weak_ff <= reg_wdata_i[`CCC_AUX_STRENGTH_BIT]; // RULE13
      aux_div_ff <= reg_wdata_i[`CCC_AUX_DIV_MSB:`CCC_AUX_DIV_LSB];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else if (ce_i) begin
      rvalid_ff <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // pin inputs: three stages, a level counts once stages two and three agree
  logic [N_PIN-1:0] meta_ff;
  logic [N_PIN-1:0] sync2_ff;
  logic [N_PIN-1:0] sync3_ff;
  logic [N_PIN-1:0] level_ff;

  wire logic [N_PIN-1:0] pin_raw = {sync_i, input_cleanup_loop_i, second_vco_divider_i, first_vco_divider_i};
  wire logic [N_PIN-1:0] agree = ~(sync2_ff ^ sync3_ff);
  wire logic [N_PIN-1:0] nxt_level = (agree & sync3_ff) | (~agree & level_ff);
  wire logic [N_PIN-1:0] pin_edge = nxt_level ^ level_ff;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      level_ff <= '0;
    end else if (ce_i) begin
      meta_ff <= pin_raw;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
      level_ff <= nxt_level;
    end
  end

  // channel clock source and divider
  wire logic use_second = src_sel_ff[SEL_BIT]; // RULE12
  wire logic src_edge = use_second ? pin_edge[PIN_M2] : pin_edge[PIN_M1]; // RULE12
  wire ccc_div_t div_value = {div_high_ff, div_low_ff}; // RULE2
  wire logic div_clk;

  ccc_chan_div #(
    .DIV_W(DIV_W),
    .PHASE_W(PHASE_W)
  ) u_chan_div (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .edge_i(src_edge),
    .sync_i(level_ff[PIN_SYNC]),
    .div_i(div_value),
    .phase_i(phase_ff),
    .clk_o(div_clk)
  );

  // driver mode decode: {pos drive, pos invert, neg drive, neg invert}
  // differential codes are not built here, so they leave both pins floating
  function automatic logic [3:0] drv_decode(input logic [3:0] mode);
    logic [3:0] d;
    d = 4'h0;
    unique case (mode)
      CCC_DRV_CMOS_TT: d = 4'b1010; // RULE5
      CCC_DRV_CMOS_TC: d = 4'b1011; // RULE6
      CCC_DRV_CMOS_TZ: d = 4'b1000; // RULE7
      CCC_DRV_CMOS_ZT: d = 4'b0010; // RULE7
      CCC_DRV_CMOS_CC: d = 4'b1111; // RULE8
      CCC_DRV_CMOS_CT: d = 4'b1110; // RULE9
      CCC_DRV_CMOS_CZ: d = 4'b1100; // RULE10
      CCC_DRV_CMOS_ZC: d = 4'b0011; // RULE11
      default: d = 4'h0;
    endcase
    return d;
  endfunction : drv_decode

  wire logic [3:0] drv = drv_decode(drv_mode_ff);
  wire logic nxt_pos = drv[3] ? (div_clk ^ drv[2]) : 1'b0;
  wire logic nxt_neg = drv[1] ? (div_clk ^ drv[0]) : 1'b0;

  // pins registered so they leave on a flop edge; one cycle behind the divider
  logic pos_ff;
  logic pos_oe_ff;
  logic neg_ff;
  logic neg_oe_ff;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_ff <= 1'b0;
      pos_oe_ff <= 1'b0;
      neg_ff <= 1'b0;
      neg_oe_ff <= 1'b0;
    end else if (ce_i) begin
      pos_ff <= nxt_pos;
      pos_oe_ff <= drv[3];
      neg_ff <= nxt_neg;
      neg_oe_ff <= drv[1];
    end
  end

  // auxiliary cleanup loop output
  ccc_aux_div u_aux_div (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .edge_i(pin_edge[PIN_CL]),
    .code_i(aux_div_ff),
    .clk_o(cleanup_loop_aux_output_o)
  );

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign chan_pos_o = pos_ff;
  assign chan_pos_oe_o = pos_oe_ff;
  assign chan_neg_o = neg_ff;
  assign chan_neg_oe_o = neg_oe_ff;
  assign cleanup_loop_aux_weak_o = aux_weak_ff; // RULE13
  assign channel_source_select_o = src_sel_ff;

endmodule : ccc_top

// ### rtl/ccc_regs.svh
// register offsets, field positions and reset values for the clock output channel config block
// included by the package, the monitor and the bench; definitions only
`ifndef CCC_REGS_SVH
`define CCC_REGS_SVH

`define CCC_ADDR_W 10
`define CCC_DATA_W 8

`define CCC_OFS_DRIVER_MODE 10'h190
`define CCC_OFS_CHAN_DIV_LOW 10'h191
`define CCC_OFS_CHAN_PHASE_DIV_HIGH 10'h192
`define CCC_OFS_AUX_OUT_CTRL 10'h1BA

`define CCC_DRV_MODE_MSB 3
`define CCC_DRV_MODE_LSB 0
`define CCC_DIV_HIGH_MSB 1
`define CCC_DIV_HIGH_LSB 0
`define CCC_PHASE_MSB 7
`define CCC_PHASE_LSB 2
`define CCC_SRC_SEL_MSB 7
`define CCC_SRC_SEL_LSB 5
`define CCC_AUX_STRENGTH_BIT 4
`define CCC_AUX_DIV_MSB 3
`define CCC_AUX_DIV_LSB 0

`define CCC_RST_DRIVER_MODE 4'h0
`define CCC_RST_DIV_LOW 8'h00
`define CCC_RST_DIV_HIGH 2'h0
`define CCC_RST_PHASE 6'h00
`define CCC_RST_SRC_SEL 3'h0
`define CCC_RST_AUX_STRENGTH 1'b0
`define CCC_RST_AUX_DIV 4'h1

`define CCC_AUX_DIV_BY1 4'h0
`define CCC_AUX_DIV_BY2 4'h1
`define CCC_AUX_DIV_BY4 4'h2
`define CCC_AUX_DIV_BY8 4'h4
`define CCC_AUX_DIV_BY16 4'h8

`endif

// ### rtl/ccc_pkg.sv
// types shared by the clock output channel config modules
// assumes ccc_regs.svh is on the include path
`include "ccc_regs.svh"

package ccc_pkg;

  typedef enum logic [1:0] {
    CCC_ST_HOLD  = 2'b00,
    CCC_ST_PHASE = 2'b01,
    CCC_ST_RUN   = 2'b10
  } ccc_div_state_e;

  typedef enum logic [3:0] {
    CCC_DRV_TRISTATE   = 4'h0,
    CCC_DRV_CMOS_TT    = 4'h6,
    CCC_DRV_CMOS_TC    = 4'h7,
    CCC_DRV_CMOS_TZ    = 4'h8,
    CCC_DRV_CMOS_ZT    = 4'h9,
    CCC_DRV_CMOS_ZZ    = 4'hA,
    CCC_DRV_CMOS_CC    = 4'hB,
    CCC_DRV_CMOS_CT    = 4'hC,
    CCC_DRV_CMOS_CZ    = 4'hD,
    CCC_DRV_CMOS_ZC    = 4'hE,
    CCC_DRV_TRISTATE_B = 4'hF
  } ccc_drv_mode_e;

  typedef logic [9:0] ccc_div_t;
  typedef logic [5:0] ccc_phase_t;

endpackage : ccc_pkg

// ### rtl/ccc_chan_div.sv
// channel divider: counts half periods of its input clock, phase offset after sync
// assumes edge_i is one pulse per rise or fall of the input clock, same clock domain
`timescale 1ns/100ps

module ccc_chan_div
  import ccc_pkg::*;
#(
  parameter int DIV_W = 10,
  parameter int PHASE_W = 6
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic edge_i,
  input wire logic sync_i,
  input wire logic [DIV_W-1:0] div_i,
  input wire logic [PHASE_W-1:0] phase_i,
  output logic clk_o
);

  ccc_div_state_e state_ff, nxt_state;
  logic [DIV_W-1:0] cnt_ff, nxt_cnt;
  logic [PHASE_W-1:0] dly_ff, nxt_dly;
  logic out_ff, nxt_out;

  // toggling every div+1 edges gives a period of div+1 input periods
  wire logic terminal = (cnt_ff == div_i); // RULE1
  wire logic dly_done = (dly_ff == PHASE_W'(1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_dly = dly_ff;
    nxt_out = out_ff;
    if (sync_i) begin
      nxt_state = CCC_ST_HOLD;
      nxt_cnt = '0;
      nxt_out = 1'b0;
    end else begin
      unique case (state_ff)
        CCC_ST_HOLD: begin
          // each phase count holds off one half period of the input
          nxt_dly = phase_i; // RULE3 RULE4
          nxt_state = (phase_i == '0) ? CCC_ST_RUN : CCC_ST_PHASE;
        end
        CCC_ST_PHASE: begin
          if (edge_i) begin
            nxt_dly = dly_ff - PHASE_W'(1); // RULE4
            if (dly_done) begin
              nxt_state = CCC_ST_RUN;
            end
          end
        end
        CCC_ST_RUN: begin
          if (edge_i) begin
            if (terminal) begin
              nxt_cnt = '0;
              nxt_out = ~out_ff; // RULE1
            end else begin
              nxt_cnt = cnt_ff + DIV_W'(1);
            end
          end
        end
        default: begin
          nxt_state = CCC_ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= CCC_ST_HOLD;
      cnt_ff <= '0;
      dly_ff <= '0;
      out_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      dly_ff <= nxt_dly;
      out_ff <= nxt_out;
    end
  end

  assign clk_o = out_ff;

endmodule : ccc_chan_div

// ### rtl/ccc_aux_div.sv
// auxiliary output divider with one-hot code, for the cleanup loop clock
// assumes edge_i is one pulse per rise or fall of the cleanup loop clock
`timescale 1ns/100ps

module ccc_aux_div
  import ccc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic edge_i,
  input wire logic [3:0] code_i,
  output logic clk_o
);

  // half-period edges between toggles, minus one
  function automatic logic [3:0] aux_limit(input logic [3:0] code);
    logic [3:0] lim;
    lim = 4'h0;
    unique case (code) // RULE14
      `CCC_AUX_DIV_BY2: lim = 4'h1;
      `CCC_AUX_DIV_BY4: lim = 4'h3;
      `CCC_AUX_DIV_BY8: lim = 4'h7;
      `CCC_AUX_DIV_BY16: lim = 4'hF;
      // divide by 1, and any code software must not write
      default: lim = 4'h0; // RULE16
    endcase
    return lim;
  endfunction : aux_limit

  logic [3:0] cnt_ff;
  logic out_ff;
  wire logic [3:0] limit = aux_limit(code_i);
  wire logic terminal = (cnt_ff >= limit);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 4'h0;
      out_ff <= 1'b0;
    end else if (ce_i && edge_i) begin
      cnt_ff <= terminal ? 4'h0 : cnt_ff + 4'h1;
      out_ff <= terminal ? ~out_ff : out_ff; // RULE14
    end
  end

  assign clk_o = out_ff;

endmodule : ccc_aux_div

// ### tb/ccc_top_monitor.sv
// checker for ccc_top port behaviour: driver modes, aux controls, read port
// bound to ccc_top from the bench; one clock domain, ports only
`timescale 1ns/100ps
`include "ccc_regs.svh"

module ccc_top_monitor (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [`CCC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`CCC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`CCC_DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic sync_i,
  input wire logic chan_pos_o,
  input wire logic chan_pos_oe_o,
  input wire logic chan_neg_o,
  input wire logic chan_neg_oe_o,
  input wire logic cleanup_loop_aux_output_o,
  input wire logic cleanup_loop_aux_weak_o,
  input wire logic [2:0] channel_source_select_o
);
  logic [3:0] mode_q_ff;
  logic [7:0] aux_q_ff;
  wire wr_mode = reg_wr_i && ce_i && (reg_addr_i == `CCC_OFS_DRIVER_MODE);
  wire wr_aux = reg_wr_i && ce_i && (reg_addr_i == `CCC_OFS_AUX_OUT_CTRL);

  // shadow copies; two stable cycles hide the output register latency
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q_ff <= 4'h0;
      aux_q_ff <= 8'h01;
    end else begin
      if (wr_mode) mode_q_ff <= reg_wdata_i[3:0];
      if (wr_aux) aux_q_ff <= reg_wdata_i;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  sequence s_mst;
    mode_q_ff == $past(mode_q_ff) && mode_q_ff == $past(mode_q_ff, 2);
  endsequence
  sequence s_ast;
    aux_q_ff == $past(aux_q_ff) && aux_q_ff == $past(aux_q_ff, 2);
  endsequence

  a_mode_in_phase: assert property (s_mst ##0 (mode_q_ff == 4'h6 || mode_q_ff == 4'hB) |->
    chan_pos_oe_o && chan_neg_oe_o && chan_pos_o == chan_neg_o) else $error("in-phase mode pins differ");
  a_mode_opposite: assert property (s_mst ##0 (mode_q_ff == 4'h7 || mode_q_ff == 4'hC) |->
    chan_pos_oe_o && chan_neg_oe_o && chan_pos_o != chan_neg_o) else $error("opposite mode pins equal");
  a_mode_pos_only: assert property (s_mst ##0 (mode_q_ff == 4'h8 || mode_q_ff == 4'hD) |->
    chan_pos_oe_o && !chan_neg_oe_o) else $error("positive-only mode enables wrong");
  a_mode_neg_only: assert property (s_mst ##0 (mode_q_ff == 4'h9 || mode_q_ff == 4'hE) |->
    !chan_pos_oe_o && chan_neg_oe_o) else $error("negative-only mode enables wrong");
  a_floating_pin_low: assert property (!chan_pos_oe_o || !chan_neg_oe_o |->
    (chan_pos_oe_o || !chan_pos_o) && (chan_neg_oe_o || !chan_neg_o)) else $error("floating pin not low");
  a_sync_hold_low: assert property (sync_i [*8] ##0 s_mst ##0 mode_q_ff == 4'h6 |-> !chan_pos_o)
    else $error("pin moved while sync held");
  a_aux_strength: assert property (s_ast |-> cleanup_loop_aux_weak_o == aux_q_ff[4])
    else $error("aux strength mismatch");
  a_src_select: assert property (s_ast |-> channel_source_select_o == aux_q_ff[7:5])
    else $error("source select mismatch");
  a_read_answer: assert property (reg_rd_i && ce_i |=> reg_rvalid_o)
    else $error("read without rvalid");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i) || !$past(ce_i))
    else $error("rvalid without read");

  c_read: cover property (reg_rvalid_o);
  c_opposite: cover property (mode_q_ff == 4'h7 && chan_neg_o);
  c_aux_clock: cover property ($rose(cleanup_loop_aux_output_o));
endmodule : ccc_top_monitor

// ### tb/tb.sv
// self-checking bench for ccc_top: registers, driver modes, dividers, phase
// all inputs driven at the falling edge; source clocks from one shared counter
`timescale 1ns/100ps
`include "ccc_regs.svh"

module tb;
  import ccc_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [9:0] reg_addr_i = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic sync_i = 1'b0;
  logic msel = 1'b0;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o, chan_pos_o, chan_pos_oe_o, chan_neg_o, chan_neg_oe_o, aux_o, aux_weak_o;
  logic [2:0] sel_o;
  int vcnt = 0;
  int n_mismatch = 0;
  int check_count = 0;
  int t, t0;
  // rows: mode code, then expected {pos_oe, neg_oe, pos, neg} with divider held at 0
  logic [7:0] rows [12] = '{8'h6C, 8'h7D, 8'h88, 8'h94, 8'hA0, 8'hBF, 8'hCE, 8'hDA, 8'hE5, 8'h00, 8'hF0, 8'h10};
  int pdiv [5] = '{0, 1, 261, 1023, 2};
  int pexp [5] = '{8, 16, 2096, 8192, 36};
  logic [3:0] acode [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
  int aexp [6] = '{10, 20, 40, 80, 160, 10};
  // source periods 8, 12 and 10 cycles, all phase-locked to vcnt
  wire first_vco = (vcnt % 8) < 4;
  wire second_vco = (vcnt % 12) < 6;
  wire cleanup = (vcnt % 10) < 5;
  wire mon = msel ? aux_o : chan_pos_o;

  always #2 clock_i = ~clock_i;
  always @(negedge clock_i) vcnt <= (vcnt + 1) % 120;

  ccc_top DUT (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .first_vco_divider_i(first_vco), .second_vco_divider_i(second_vco),
    .input_cleanup_loop_i(cleanup), .sync_i(sync_i), .chan_pos_o(chan_pos_o), .chan_pos_oe_o(chan_pos_oe_o),
    .chan_neg_o(chan_neg_o), .chan_neg_oe_o(chan_neg_oe_o), .cleanup_loop_aux_output_o(aux_o),
    .cleanup_loop_aux_weak_o(aux_weak_o), .channel_source_select_o(sel_o));

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask : wr

  task rd(input logic [9:0] a, input logic [7:0] e);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    chk(reg_rvalid_o, 1'b1, "rvalid");
    chk(reg_rdata_o, e, "rdata");
  endtask : rd

  task setdiv(input logic [9:0] d, input logic [5:0] ph);
    wr(`CCC_OFS_CHAN_DIV_LOW, d[7:0]);
    wr(`CCC_OFS_CHAN_PHASE_DIV_HIGH, {ph, d[9:8]});
  endtask : setdiv

  // restart the divider with release aligned to the source clocks
  task resync;
    @(negedge clock_i);
    sync_i = 1'b1;
    repeat (12) @(negedge clock_i);
    while (vcnt != 0) @(negedge clock_i);
    sync_i = 1'b0;
  endtask : resync

  task rise(output int n);
    logic p;
    n = 0;
    while (n < 20000) begin
      p = mon;
      @(negedge clock_i);
      n++;
      if (!p && mon) break;
    end
  endtask : rise

  // first period after a change may be partial, so skip it
  task meas(output int p);
    int n;
    rise(n);
    rise(n);
    rise(p);
  endtask : meas

  initial begin
    #(4 * 90000);
    n_mismatch++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (20) @(negedge clock_i);
    rstn_i = 1'b1;
    sync_i = 1'b1;
    foreach (rows[i]) begin
      wr(`CCC_OFS_DRIVER_MODE, {4'h0, rows[i][7:4]});
      repeat (10) @(negedge clock_i);
      chk({chan_pos_oe_o, chan_neg_oe_o, chan_pos_o, chan_neg_o}, rows[i][3:0], "pins");
    end
    rd(`CCC_OFS_CHAN_DIV_LOW, 8'h00);
    rd(`CCC_OFS_CHAN_PHASE_DIV_HIGH, 8'h00);
    rd(`CCC_OFS_AUX_OUT_CTRL, 8'h01);
    wr(`CCC_OFS_CHAN_DIV_LOW, 8'hA5);
    rd(`CCC_OFS_CHAN_DIV_LOW, 8'hA5);
    ce_i = 1'b0;
    wr(`CCC_OFS_CHAN_DIV_LOW, 8'h5A);
    ce_i = 1'b1;
    rd(`CCC_OFS_CHAN_DIV_LOW, 8'hA5);
    wr(`CCC_OFS_CHAN_PHASE_DIV_HIGH, 8'hFF);
    rd(`CCC_OFS_CHAN_PHASE_DIV_HIGH, 8'hFF);
    wr(10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00);
    wr(`CCC_OFS_AUX_OUT_CTRL, 8'hB0);
    repeat (2) @(negedge clock_i);
    chk(sel_o, 3'b101, "select");
    chk(aux_weak_o, 1'b1, "weak");
    wr(`CCC_OFS_DRIVER_MODE, 8'h06);
    foreach (pdiv[i]) begin
      wr(`CCC_OFS_AUX_OUT_CTRL, (i == 4) ? 8'h21 : 8'h01);
      setdiv(pdiv[i][9:0], 6'h00);
      resync;
      meas(t);
      chk(t, pexp[i], "period");
    end
    chk(aux_weak_o, 1'b0, "strong");
    // phase steps are counted in half periods of the first divider input, 4 cycles each
    wr(`CCC_OFS_AUX_OUT_CTRL, 8'h01);
    setdiv(10'd1, 6'd0);
    resync;
    rise(t0);
    setdiv(10'd1, 6'd63);
    resync;
    rise(t);
    chk(t - t0, 63 * 4, "phase 63");
    setdiv(10'd1, 6'd1);
    resync;
    rise(t);
    chk(t - t0, 4, "phase 1");
    msel = 1'b1;
    foreach (acode[i]) begin
      wr(`CCC_OFS_AUX_OUT_CTRL, {4'h0, acode[i]});
      meas(t);
      chk(t, aexp[i], "aux period");
    end
    rstn_i = 1'b0;
    repeat (3) @(negedge clock_i);
    chk({chan_pos_oe_o, chan_neg_oe_o, reg_rvalid_o}, 3'b000, "reset outputs");
    rstn_i = 1'b1;
    rd(`CCC_OFS_AUX_OUT_CTRL, 8'h01);
    end_sim();
  end
endmodule : tb

bind ccc_top ccc_top_monitor u_mon (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .sync_i(sync_i), .chan_pos_o(chan_pos_o), .chan_pos_oe_o(chan_pos_oe_o),
  .chan_neg_o(chan_neg_o), .chan_neg_oe_o(chan_neg_oe_o), .cleanup_loop_aux_output_o(cleanup_loop_aux_output_o),
  .cleanup_loop_aux_weak_o(cleanup_loop_aux_weak_o), .channel_source_select_o(channel_source_select_o));
